// ==== design/udgc_top.sv ====
// USB device global control: registers, flags, suspend and resume control
`default_nettype none
module udgc_top #(
    parameter int SUSPEND_CYCLES = udgc_pkg::SUSPEND_CYCLES,
    parameter int RESUME_CYCLES = udgc_pkg::RESUME_CYCLES,
    parameter logic [3:0] EP_COUNT = 4'h7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic bus_reset,
    input wire logic bus_idle_j,
    input wire logic bus_nonidle,
    input wire logic sof_seen,
    input wire logic [10:0] sof_frame,
    input wire logic end_of_host_resume,
    input wire logic [6:0] ep_irq,
    output logic global_nak_force,
    output logic low_speed_force,
    output logic pullup_detached,
    output logic resume_drive,
    output logic address_valid,
    output logic [6:0] device_address,
    output logic [10:0] frame_number,
    output logic usb_irq
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic idle_s;
    logic nonidle_s;
    udgc_sync u_sync_idle (
        .clk(clk),
        .reset(reset),
        .din(bus_idle_j),
        .dout(idle_s)
    );
    udgc_sync u_sync_wake (
        .clk(clk),
        .reset(reset),
        .din(bus_nonidle),
        .dout(nonidle_s)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_ctrl = reg_write && (reg_addr == udgc_pkg::OFF_DEV_CTRL);
    wire wr_iclr = reg_write && (reg_addr == udgc_pkg::OFF_INT_CLR);
    wire wr_iset = reg_write && (reg_addr == udgc_pkg::OFF_INT_SET);
    wire wr_eclr = reg_write && (reg_addr == udgc_pkg::OFF_INT_EN_CLR);
    wire wr_eset = reg_write && (reg_addr == udgc_pkg::OFF_INT_EN_SET);
    wire wr_gen = reg_write && (reg_addr == udgc_pkg::OFF_GEN_CTRL);
    wire wr_desc = reg_write && (reg_addr == udgc_pkg::OFF_DESC_BASE);

    logic [31:0] gen_ctrl_q;
    logic [31:0] desc_q;
    logic nak_force_q;
    logic low_speed_q;
    logic detach_q;
    logic addr_valid_q;
    logic [6:0] dev_addr_q;
    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [31:0] inten_q;
    logic [10:0] fnum_q;
    udgc_pkg::udgc_resume_e rs_q;
    udgc_pkg::udgc_resume_e rs_d;
    logic [$clog2(RESUME_CYCLES+1)-1:0] rs_cnt_q;

    wire frozen = gen_ctrl_q[udgc_pkg::BIT_CLK_FREEZE] || !gen_ctrl_q[udgc_pkg::BIT_CTRL_ENABLE];
    wire ctrl_ok = wr_ctrl && !frozen;
    wire resume_busy = (rs_q == udgc_pkg::UDGC_RS_SEND);

    // ------------------------------------------------------------------
    // Control and descriptor registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gen_ctrl_q <= udgc_pkg::GEN_CTRL_RESET;
            desc_q <= '0;
        end else begin
            if (wr_gen) begin
                gen_ctrl_q <= reg_wdata & udgc_pkg::GEN_CTRL_WMASK;
            end
            if (wr_desc) begin
                desc_q <= reg_wdata & udgc_pkg::DESC_ALIGN_MASK;
            end
        end
    end

    // Speed bit sits outside the enable gating so disable never touches it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_speed_q <= udgc_pkg::DEV_CTRL_RESET[udgc_pkg::BIT_LOW_SPEED];
        end else if (wr_ctrl) begin
            low_speed_q <= reg_wdata[udgc_pkg::BIT_LOW_SPEED];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nak_force_q <= udgc_pkg::DEV_CTRL_RESET[udgc_pkg::BIT_NAK_FORCE];
            detach_q <= udgc_pkg::DEV_CTRL_RESET[udgc_pkg::BIT_DETACH];
            addr_valid_q <= 1'b0;
            dev_addr_q <= '0;
        end else if (bus_reset) begin
            addr_valid_q <= 1'b0;
            dev_addr_q <= '0;
        end else if (ctrl_ok) begin
            nak_force_q <= reg_wdata[udgc_pkg::BIT_NAK_FORCE];
            detach_q <= reg_wdata[udgc_pkg::BIT_DETACH];
            dev_addr_q <= reg_wdata[6:0];
            if (reg_wdata[udgc_pkg::BIT_ADDR_VALID]) begin
                addr_valid_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Upstream resume sequencer
    // ------------------------------------------------------------------
    wire rs_start = ctrl_ok && reg_wdata[udgc_pkg::BIT_REMOTE_WAKE];
    wire rs_end = (rs_cnt_q == RESUME_CYCLES[$clog2(RESUME_CYCLES+1)-1:0]);

    always_comb begin
        rs_d = rs_q;
        unique case (rs_q)
            udgc_pkg::UDGC_RS_IDLE: begin
                if (rs_start) begin
                    rs_d = udgc_pkg::UDGC_RS_SEND;
                end
            end
            udgc_pkg::UDGC_RS_SEND: begin
                if (bus_reset) begin
                    rs_d = udgc_pkg::UDGC_RS_IDLE;
                end else if (rs_end) begin
                    rs_d = udgc_pkg::UDGC_RS_DONE;
                end
            end
            udgc_pkg::UDGC_RS_DONE: begin
                rs_d = udgc_pkg::UDGC_RS_IDLE;
            end
            default: begin
                rs_d = udgc_pkg::UDGC_RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rs_q <= udgc_pkg::UDGC_RS_IDLE;
            rs_cnt_q <= '0;
        end else begin
            rs_q <= rs_d;
            rs_cnt_q <= resume_busy ? rs_cnt_q + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------------
    // Suspend detection
    // ------------------------------------------------------------------
    logic idle_expired;
    logic idle_expired_q;
    udgc_timer #(
        .LIMIT(SUSPEND_CYCLES)
    ) u_idle_timer (
        .clk(clk),
        .reset(reset),
        .run(idle_s),
        .expired(idle_expired)
    );
    logic nonidle_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_expired_q <= 1'b0;
            nonidle_q <= 1'b0;
        end else begin
            idle_expired_q <= idle_expired;
            nonidle_q <= nonidle_s;
        end
    end
    wire bus_idle_flag_ev = idle_expired && !idle_expired_q;
    wire wake_ev = nonidle_s && !nonidle_q;

    // ------------------------------------------------------------------
    // Interrupt flags, hardware set wins over software clear
    // ------------------------------------------------------------------
    logic [31:0] hw_set;
    always_comb begin
        hw_set = '0;
        hw_set[udgc_pkg::BIT_BUS_IDLE] = bus_idle_flag_ev;
        hw_set[udgc_pkg::BIT_SOF] = sof_seen;
        hw_set[udgc_pkg::BIT_RESET_END] = bus_reset;
        hw_set[udgc_pkg::BIT_WAKEUP] = wake_ev;
        hw_set[udgc_pkg::BIT_HOST_RESUME_END] = end_of_host_resume;
        hw_set[udgc_pkg::BIT_UP_RESUME] = rs_start && (rs_q == udgc_pkg::UDGC_RS_IDLE);
    end

    wire [31:0] sw_set = wr_iset ? (reg_wdata & udgc_pkg::GLOBAL_MASK) : 32'h00000000;
    // Clears are taken even while frozen, so software can always acknowledge
    wire [31:0] sw_clr = wr_iclr ? (reg_wdata & udgc_pkg::GLOBAL_MASK) : 32'h00000000;

    always_comb begin
        flags_d = (flags_q & ~sw_clr) | sw_set | hw_set;
        if (hw_set[udgc_pkg::BIT_WAKEUP]) begin
            flags_d[udgc_pkg::BIT_BUS_IDLE] = 1'b0;
        end
        if (hw_set[udgc_pkg::BIT_BUS_IDLE]) begin
            flags_d[udgc_pkg::BIT_WAKEUP] = 1'b0;
        end
        // Endpoint summaries follow their sources; no direct write path
        flags_d[udgc_pkg::BIT_EP0 +: udgc_pkg::NUM_EP] = ep_irq;
        flags_d = flags_d & (udgc_pkg::GLOBAL_MASK | udgc_pkg::EP_MASK);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q <= '0;
            inten_q <= '0;
            fnum_q <= '0;
        end else begin
            flags_q <= flags_d;
            if (wr_eset) begin
                inten_q <= inten_q | (reg_wdata & (udgc_pkg::GLOBAL_MASK | udgc_pkg::EP_MASK));
            end else if (wr_eclr) begin
                inten_q <= inten_q & ~reg_wdata;
            end
            if (sof_seen) begin
                fnum_q <= sof_frame;
            end
        end
    end

    assign usb_irq = |(flags_q & inten_q);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [31:0] ctrl_rd = {14'h0000, nak_force_q, 4'h0, low_speed_q, 2'h0, resume_busy, detach_q, addr_valid_q, dev_addr_q};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                udgc_pkg::OFF_DEV_CTRL: reg_rdata <= ctrl_rd;
                udgc_pkg::OFF_DEV_INT: reg_rdata <= flags_q;
                udgc_pkg::OFF_INT_EN: reg_rdata <= inten_q;
                udgc_pkg::OFF_GEN_CTRL: reg_rdata <= gen_ctrl_q;
                udgc_pkg::OFF_FEATURES: reg_rdata <= {28'h0000000, EP_COUNT};
                udgc_pkg::OFF_REGION_SIZE: reg_rdata <= udgc_pkg::REGION_SIZE;
                udgc_pkg::OFF_LABEL_LOW: reg_rdata <= udgc_pkg::LABEL_LOW;
                udgc_pkg::OFF_LABEL_HIGH: reg_rdata <= udgc_pkg::LABEL_HIGH;
                udgc_pkg::OFF_ROLE_STATE: reg_rdata <= {28'h0000000, udgc_pkg::ROLE_DEVICE};
                udgc_pkg::OFF_DESC_BASE: reg_rdata <= desc_q;
                default: reg_rdata <= '0;
            endcase
        end
    end

    assign global_nak_force = nak_force_q;
    assign low_speed_force = low_speed_q;
    assign pullup_detached = detach_q;
    assign resume_drive = resume_busy;
    assign address_valid = addr_valid_q;
    assign device_address = dev_addr_q;
    assign frame_number = fnum_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_resume_req;
        rs_start && (rs_q == udgc_pkg::UDGC_RS_IDLE);
    endsequence
    a_resume_start: assert property (@(posedge clk) disable iff (reset)
        s_resume_req |=> resume_drive) else $error("resume not started");
    a_resume_reset: assert property (@(posedge clk) disable iff (reset)
        (resume_drive && bus_reset) |=> !resume_drive) else $error("resume survives bus reset");
    a_addr_reset: assert property (@(posedge clk) disable iff (reset)
        bus_reset |=> !address_valid && device_address == 7'h00) else $error("address kept over reset");
    a_desc_align: assert property (@(posedge clk) disable iff (reset)
        desc_q[2:0] == 3'h0) else $error("descriptor misaligned");
    a_speed_write: assert property (@(posedge clk) disable iff (reset)
        wr_ctrl |=> low_speed_force == $past(reg_wdata[udgc_pkg::BIT_LOW_SPEED])) else $error("speed write lost");
    a_ctrl_refused: assert property (@(posedge clk) disable iff (reset)
        (wr_ctrl && frozen && !bus_reset) |=> $stable(global_nak_force) && $stable(address_valid))
        else $error("control write taken while frozen");
    a_resume_end: assert property (@(posedge clk) disable iff (reset)
        (resume_drive && rs_end && !bus_reset) |=> !resume_drive) else $error("resume not ended");
    a_wake_clear: assert property (@(posedge clk) disable iff (reset)
        wake_ev |=> !flags_q[udgc_pkg::BIT_BUS_IDLE] && flags_q[udgc_pkg::BIT_WAKEUP]) else $error("wake flag wrong");
    a_ep_upper: assert property (@(posedge clk) disable iff (reset)
        flags_q[31:19] == 13'h0000) else $error("upper endpoint flag set");
    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        (sof_seen && inten_q[udgc_pkg::BIT_SOF] && !wr_eclr) |=> usb_irq) else $error("enabled flag gave no interrupt");
    a_sof_flag: assert property (@(posedge clk) disable iff (reset)
        sof_seen |=> flags_q[udgc_pkg::BIT_SOF] && frame_number == $past(sof_frame)) else $error("sof not recorded");
endmodule
`default_nettype wire

// ==== inc/udgc_pkg.sv ====
// Constants, register map and field layout for the USB device global control block
`default_nettype none
package udgc_pkg;
    localparam logic [11:0] OFF_DEV_CTRL = 12'h000;
    localparam logic [11:0] OFF_DEV_INT = 12'h004;
    localparam logic [11:0] OFF_INT_CLR = 12'h008;
    localparam logic [11:0] OFF_INT_SET = 12'h00C;
    localparam logic [11:0] OFF_INT_EN = 12'h010;
    localparam logic [11:0] OFF_INT_EN_CLR = 12'h014;
    localparam logic [11:0] OFF_INT_EN_SET = 12'h018;
    localparam logic [11:0] OFF_GEN_CTRL = 12'h800;
    localparam logic [11:0] OFF_FEATURES = 12'h81C;
    localparam logic [11:0] OFF_REGION_SIZE = 12'h820;
    localparam logic [11:0] OFF_LABEL_LOW = 12'h824;
    localparam logic [11:0] OFF_LABEL_HIGH = 12'h828;
    localparam logic [11:0] OFF_ROLE_STATE = 12'h82C;
    localparam logic [11:0] OFF_DESC_BASE = 12'h830;

    localparam int BIT_NAK_FORCE = 17;
    localparam int BIT_LOW_SPEED = 12;
    localparam int BIT_REMOTE_WAKE = 9;
    localparam int BIT_DETACH = 8;
    localparam int BIT_ADDR_VALID = 7;
    localparam int BIT_CTRL_ENABLE = 15;
    localparam int BIT_CLK_FREEZE = 14;
    localparam logic [31:0] GEN_CTRL_WMASK = 32'h0000C000;
    localparam int BIT_BUS_IDLE = 0;
    localparam int BIT_SOF = 2;
    localparam int BIT_RESET_END = 3;
    localparam int BIT_WAKEUP = 4;
    localparam int BIT_HOST_RESUME_END = 5;
    localparam int BIT_UP_RESUME = 6;
    localparam int BIT_EP0 = 12;
    localparam int NUM_EP = 7;
    localparam logic [31:0] GLOBAL_MASK = 32'h0000007D;
    localparam logic [31:0] EP_MASK = 32'h0007F000;

    localparam logic [31:0] DEV_CTRL_RESET = 32'h00000100;
    localparam logic [31:0] GEN_CTRL_RESET = 32'h00004000;
    localparam logic [3:0] ROLE_DEVICE = 4'h9;
    localparam logic [31:0] DESC_ALIGN_MASK = 32'hFFFFFFF8;
    // Arbitrary neutral identity values
    localparam logic [31:0] REGION_SIZE = 32'h00001000;
    localparam logic [31:0] LABEL_LOW = 32'h55534244;
    localparam logic [31:0] LABEL_HIGH = 32'h45560000;

    localparam int CLK_HZ = 20000000;
    localparam int SUSPEND_TIME_US = 3000;
    localparam int SUSPEND_CYCLES = CLK_HZ / 1000000 * SUSPEND_TIME_US;
    localparam int RESUME_TIME_US = 1000;
    localparam int RESUME_CYCLES = CLK_HZ / 1000000 * RESUME_TIME_US;

    typedef enum logic [1:0] {
        UDGC_RS_IDLE = 2'b00,
        UDGC_RS_SEND = 2'b01,
        UDGC_RS_DONE = 2'b10
    } udgc_resume_e;
endpackage
`default_nettype wire

// ==== design/udgc_sync.sv ====
// Three-stage input synchroniser with agreement filter
`default_nettype none
module udgc_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/udgc_timer.sv ====
// Saturating run-length counter that flags when a level lasted long enough
`default_nettype none
module udgc_timer #(
    parameter int LIMIT = 60000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    output logic expired
);
    logic [$clog2(LIMIT+1)-1:0] cnt_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != LIMIT[$clog2(LIMIT+1)-1:0]) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign expired = (cnt_q == LIMIT[$clog2(LIMIT+1)-1:0]);
endmodule
`default_nettype wire

// ==== tb/udgc_host_model.sv ====
// Behavioural upstream host driving bus reset, idle, wakeup and frame markers
`default_nettype none
module udgc_host_model (
    input wire logic clk,
    output logic bus_reset,
    output logic bus_idle_j,
    output logic bus_nonidle,
    output logic sof_seen,
    output logic [10:0] sof_frame,
    output logic end_of_host_resume
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_reset = 1'b0;
        bus_idle_j = 1'b0;
        bus_nonidle = 1'b0;
        sof_seen = 1'b0;
        sof_frame = 11'h000;
        end_of_host_resume = 1'b0;
    end

    // A reset drives SE0, so the bus is neither idle nor signalling
    task automatic send_reset(input int n);
        @(posedge clk);
        bus_reset <= 1'b1;
        bus_idle_j <= 1'b0;
        repeat (n) @(posedge clk);
        bus_reset <= 1'b0;
    endtask

    // Frame number is not held after the marker, so stale values cannot pass
    task automatic send_sof(input logic [10:0] f);
        @(posedge clk);
        sof_seen <= 1'b1;
        sof_frame <= f;
        @(posedge clk);
        sof_seen <= 1'b0;
        sof_frame <= ~f;
    endtask

    task automatic set_idle();
        @(posedge clk);
        bus_idle_j <= 1'b1;
    endtask

    // Long enough for the agreement filter to accept the activity
    task automatic wake();
        @(posedge clk);
        bus_idle_j <= 1'b0;
        bus_nonidle <= 1'b1;
        repeat (6) @(posedge clk);
        bus_nonidle <= 1'b0;
    endtask

    task automatic resume_end();
        @(posedge clk);
        end_of_host_resume <= 1'b1;
        @(posedge clk);
        end_of_host_resume <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/udgc_top_tb.sv ====
// Self-checking bench for the USB device global control block
`default_nettype none
module udgc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUS_IDLE_FLAG_CYC = 20;
    localparam int RES_CYC = 8;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    logic bus_reset, bus_idle_j, bus_nonidle, sof_seen, end_of_host_resume;
    logic [10:0] sof_frame, frame_number;
    logic [6:0] ep_irq = 7'h00;
    logic [6:0] device_address;
    logic global_nak_force, low_speed_force, pullup_detached, resume_drive, address_valid, usb_irq;
    int err_total = 0;
    int compares = 0;

    always #25 clk = ~clk;

    udgc_top #(.SUSPEND_CYCLES(BUS_IDLE_FLAG_CYC), .RESUME_CYCLES(RES_CYC), .EP_COUNT(4'h7)) udgc_top_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_reset(bus_reset), .bus_idle_j(bus_idle_j),
        .bus_nonidle(bus_nonidle), .sof_seen(sof_seen), .sof_frame(sof_frame),
        .end_of_host_resume(end_of_host_resume), .ep_irq(ep_irq), .global_nak_force(global_nak_force),
        .low_speed_force(low_speed_force), .pullup_detached(pullup_detached), .resume_drive(resume_drive),
        .address_valid(address_valid), .device_address(device_address), .frame_number(frame_number),
        .usb_irq(usb_irq));

    udgc_host_model udgc_host_model_i (
        .clk(clk), .bus_reset(bus_reset), .bus_idle_j(bus_idle_j), .bus_nonidle(bus_nonidle),
        .sof_seen(sof_seen), .sof_frame(sof_frame), .end_of_host_resume(end_of_host_resume));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        reg_rd(a, v);
        chk(name, exp, v);
    endtask

    // Polls the flag register under a bound; the caller judges the result
    task automatic wait_flag(input int b);
        logic [31:0] v;
        v = 32'h00000000;
        for (int i = 0; i < 100 && v[b] !== 1'b1; i++) begin
            reg_rd(udgc_pkg::OFF_DEV_INT, v);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        logic [11:0] addr [9];
        logic [31:0] expv [9];
        addr = '{12'h000, 12'h004, 12'h81C, 12'h820, 12'h824, 12'h828, 12'h82C, 12'h830, 12'h7F0};
        expv = '{32'h00000100, 32'h00000000, 32'h00000007, udgc_pkg::REGION_SIZE, udgc_pkg::LABEL_LOW,
                 udgc_pkg::LABEL_HIGH, 32'h00000009, 32'h00000000, 32'h00000000};
        chk("detached", 32'h1, pullup_detached);
        reg_wr(12'h7F0, 32'hFFFFFFFF);
        for (int i = 0; i < 9; i++) begin
            rd_chk("reset value", addr[i], expv[i]);
        end
    endtask

    // Control writes are refused while frozen, except the speed bit
    task automatic t_control_gate();
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00021000);
        settle(1);
        chk("ls frozen", 32'h1, low_speed_force);
        chk("global_nak_force frozen", 32'h0, global_nak_force);
        rd_chk("ctrl frozen", udgc_pkg::OFF_DEV_CTRL, 32'h00001100);
        reg_wr(udgc_pkg::OFF_GEN_CTRL, 32'h00008000);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00021000);
        settle(1);
        chk("global_nak_force on", 32'h1, global_nak_force);
        chk("attached", 32'h0, pullup_detached);
        reg_wr(udgc_pkg::OFF_GEN_CTRL, 32'h00000000);
        settle(1);
        chk("ls kept", 32'h1, low_speed_force);
        reg_wr(udgc_pkg::OFF_GEN_CTRL, 32'h00008000);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000100);
        settle(1);
        chk("full speed", 32'h0, low_speed_force);
        chk("global_nak_force off", 32'h0, global_nak_force);
        chk("detach again", 32'h1, pullup_detached);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000000);
    endtask

    task automatic t_address();
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000005);
        settle(1);
        chk("addr field", 32'h5, device_address);
        chk("addr off", 32'h0, address_valid);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000085);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000005);
        settle(1);
        chk("addr kept on", 32'h1, address_valid);
        udgc_host_model_i.send_reset(3);
        settle(2);
        chk("addr en reset", 32'h0, address_valid);
        chk("addr reset", 32'h0, device_address);
        rd_chk("ctrl after reset", udgc_pkg::OFF_DEV_CTRL, 32'h00000000);
        rd_chk("reset end flag", udgc_pkg::OFF_DEV_INT, 32'h00000008);
    endtask

    task automatic t_resume();
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000200);
        settle(1);
        chk("resume start", 32'h1, resume_drive);
        settle(RES_CYC - 2);
        chk("resume held", 32'h1, resume_drive);
        settle(4);
        chk("resume done", 32'h0, resume_drive);
        rd_chk("wakeup bit", udgc_pkg::OFF_DEV_CTRL, 32'h00000000);
        rd_chk("resume flag", udgc_pkg::OFF_DEV_INT, 32'h00000048);
        reg_wr(udgc_pkg::OFF_DEV_CTRL, 32'h00000200);
        settle(2);
        udgc_host_model_i.send_reset(2);
        settle(1);
        chk("resume aborted", 32'h0, resume_drive);
    endtask

    task automatic t_descriptor();
        reg_wr(udgc_pkg::OFF_DESC_BASE, 32'hFFFFFFFF);
        rd_chk("desc ones", udgc_pkg::OFF_DESC_BASE, 32'hFFFFFFF8);
        reg_wr(udgc_pkg::OFF_DESC_BASE, 32'h12345677);
        rd_chk("desc value", udgc_pkg::OFF_DESC_BASE, 32'h12345670);
    endtask

    task automatic t_global_flags();
        reg_wr(udgc_pkg::OFF_INT_CLR, 32'h0000007D);
        udgc_host_model_i.set_idle();
        rd_chk("idle early", udgc_pkg::OFF_DEV_INT, 32'h00000000);
        wait_flag(0);
        rd_chk("suspend", udgc_pkg::OFF_DEV_INT, 32'h00000001);
        reg_wr(udgc_pkg::OFF_GEN_CTRL, 32'h0000C000);
        udgc_host_model_i.wake();
        wait_flag(4);
        rd_chk("wake frozen", udgc_pkg::OFF_DEV_INT, 32'h00000010);
        reg_wr(udgc_pkg::OFF_GEN_CTRL, 32'h00008000);
        udgc_host_model_i.set_idle();
        wait_flag(0);
        rd_chk("suspend again", udgc_pkg::OFF_DEV_INT, 32'h00000001);
        reg_wr(udgc_pkg::OFF_INT_CLR, 32'h0000007D);
        udgc_host_model_i.send_sof(11'h5A5);
        settle(1);
        chk("frame", 32'h5A5, frame_number);
        rd_chk("sof flag", udgc_pkg::OFF_DEV_INT, 32'h00000004);
        reg_wr(udgc_pkg::OFF_INT_EN_SET, 32'h00000004);
        settle(1);
        chk("irq on", 32'h1, usb_irq);
        rd_chk("enable read", udgc_pkg::OFF_INT_EN, 32'h00000004);
        reg_wr(udgc_pkg::OFF_INT_CLR, 32'h00000004);
        udgc_host_model_i.resume_end();
        settle(1);
        chk("irq off", 32'h0, usb_irq);
        rd_chk("host resume", udgc_pkg::OFF_DEV_INT, 32'h00000020);
        reg_wr(udgc_pkg::OFF_INT_EN_CLR, 32'hFFFFFFFF);
        reg_wr(udgc_pkg::OFF_INT_SET, 32'hFFFFFFFF);
        rd_chk("flag set", udgc_pkg::OFF_DEV_INT, 32'h0000007D);
        rd_chk("gen ctrl", udgc_pkg::OFF_GEN_CTRL, 32'h00008000);
        reg_wr(udgc_pkg::OFF_INT_CLR, 32'h0000007D);
    endtask

    task automatic t_endpoints();
        for (int n = 0; n < 7; n++) begin
            @(posedge clk);
            ep_irq <= 7'h01 << n;
            settle(2);
            rd_chk("ep flag", udgc_pkg::OFF_DEV_INT, 32'h00001000 << n);
        end
        reg_wr(udgc_pkg::OFF_INT_CLR, 32'h0007F000);
        rd_chk("ep no clear", udgc_pkg::OFF_DEV_INT, 32'h00040000);
        reg_wr(udgc_pkg::OFF_INT_EN_SET, 32'h0007F000);
        settle(1);
        chk("ep irq", 32'h1, usb_irq);
        @(posedge clk);
        ep_irq <= 7'h00;
        settle(3);
        chk("ep irq off", 32'h0, usb_irq);
        rd_chk("ep serviced", udgc_pkg::OFF_DEV_INT, 32'h00000000);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_control_gate();
        t_address();
        t_resume();
        t_descriptor();
        t_global_flags();
        t_endpoints();
        finish_test();
    end

    // Whole sequence needs a few hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[FAIL] run expected completion seen timeout");
        finish_test();
    end
endmodule
`default_nettype wire
